// ===== hdl/itm_ctl.sv
// Purpose: Interrupt pin routing, timing and measurement control registers
// Assumes: Register strobes come from the serial port logic on clk_i
// Notes:   Pins are tri-state as data, enable pairs; enable low drives
// ==============================================================
// What this block does
// - Map bits 6:4 and 0 route functions to pin; bits 3:1 reserved
// - Map bit 7 selects active-low pin
// - Enabled functions OR together per pin
// - No function mapped leaves pin undriven
// - Pin A map bit positions fixed
// - Pin B map uses same layout
// - Rate bits 7:5 choose data rate
// - Rate bits 4:2 choose wake period
// - Bit 1 external clock, bit 0 trigger
// - Autosleep enters wake on inactivity
// - Autosleep ignored outside linked/looped mode
// - Default mode: simultaneous, host acknowledges
// - Linked mode: one detector, host acknowledges
// - Looped mode: alternate, acknowledged internally
// - Chaining needs both detect enables set
// - Measurement_control bit 3 selects low noise
// - Measurement_control bits 2:0 select filter cutoff
`timescale 1ns/10ps
`include "itm_consts.svh"

module itm_ctl #(
   parameter int unsigned CYC_PER_MS = `ITM_CYC_PER_MS
) (
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   input  wire itm_pkg::itm_req_t    req_i,
   input  wire itm_pkg::itm_events_t events_i,
   input  wire logic                 activity_detect_enable_i,
   input  wire logic                 inactivity_detect_enable_i,
   input  wire logic                 status_read_i,
   output logic [7:0]                rdata_o,
   output logic                      irq_pin_a_o,
   output logic                      irq_pin_a_oe_n_o,
   output logic                      irq_pin_b_o,
   output logic                      irq_pin_b_oe_n_o,
   output itm_pkg::itm_rate_t        rate_o,
   output itm_pkg::itm_meas_t        meas_o,
   output logic [15:0]               odr_hz_o,
   output logic [31:0]               wake_cycles_o,
   output logic                      activity_watch_o,
   output logic                      inactivity_watch_o,
   output logic                      enter_wake_o,
   output logic                      host_ack_needed_o
);
   import itm_pkg::*;

   // ==============================================================
   // Register bank
   itm_map_t   map_a_ff,  nxt_map_a;
   itm_map_t   map_b_ff,  nxt_map_b;
   itm_rate_t  rate_ff,   nxt_rate;
   itm_meas_t  meas_ff,   nxt_meas;
   logic [7:0] rdata_ff,  nxt_rdata;

   always_comb begin
      nxt_map_a = map_a_ff;
      nxt_map_b = map_b_ff;
      nxt_rate  = rate_ff;
      nxt_meas  = meas_ff;
      nxt_rdata = rdata_ff;
      if (req_i.wr) begin
         // Reserved bits masked on write
         if (req_i.addr == `ITM_OFS_PIN_A_MAP) begin
            nxt_map_a = itm_map_t'(req_i.wdata & `ITM_MAP_WMASK);
         end else if (req_i.addr == `ITM_OFS_PIN_B_MAP) begin
            nxt_map_b = itm_map_t'(req_i.wdata & `ITM_MAP_WMASK);
         end else if (req_i.addr == `ITM_OFS_RATE_SYNC) begin
            nxt_rate = itm_rate_t'(req_i.wdata & `ITM_RATE_WMASK);
         end else if (req_i.addr == `ITM_OFS_MEASUREMENT_CONTROL) begin
            nxt_meas = itm_meas_t'(req_i.wdata & `ITM_MEAS_WMASK);
         end
      end
      if (req_i.rd) begin
         // Unmapped addresses read zero
         if (req_i.addr == `ITM_OFS_PIN_A_MAP) begin
            nxt_rdata = map_a_ff;
         end else if (req_i.addr == `ITM_OFS_PIN_B_MAP) begin
            nxt_rdata = map_b_ff;
         end else if (req_i.addr == `ITM_OFS_RATE_SYNC) begin
            nxt_rdata = rate_ff;
         end else if (req_i.addr == `ITM_OFS_MEASUREMENT_CONTROL) begin
            nxt_rdata = meas_ff;
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         map_a_ff <= itm_map_t'(`ITM_RST_VAL);
         map_b_ff <= itm_map_t'(`ITM_RST_VAL);
         rate_ff  <= itm_rate_t'(`ITM_RST_VAL);
         meas_ff  <= itm_meas_t'(`ITM_RST_VAL);
         rdata_ff <= 8'h00;
      end else begin
         map_a_ff <= nxt_map_a;
         map_b_ff <= nxt_map_b;
         rate_ff  <= nxt_rate;
         meas_ff  <= nxt_meas;
         rdata_ff <= nxt_rdata;
      end
   end

   // ==============================================================
   // Activity and inactivity chaining
   itm_mode_t  mode;
   itm_phase_t phase_ff, nxt_phase;
   logic       act_watch, inact_watch, wake_req;

   always_comb begin
      // Chaining only with both detectors on
      mode = ITM_SIMULTANEOUS;
      if (activity_detect_enable_i && inactivity_detect_enable_i) begin
         if (meas_ff.act_inact_chaining == `ITM_CHAIN_LINKED) begin
            mode = ITM_LINKED;
         end else if (meas_ff.act_inact_chaining == `ITM_CHAIN_LOOPED) begin
            mode = ITM_LOOPED;
         end
      end
      nxt_phase   = phase_ff;
      act_watch   = activity_detect_enable_i;
      inact_watch = inactivity_detect_enable_i;
      wake_req    = 1'b0;
      case (mode)
         ITM_SIMULTANEOUS: begin
            nxt_phase = ITM_WATCH_ACT;
         end
         default: begin
            // One detector at a time, in sequence
            act_watch   = (phase_ff == ITM_WATCH_ACT);
            inact_watch = (phase_ff == ITM_WATCH_INACT);
            // Linked waits on the host read; looped moves on by itself
            if (phase_ff == ITM_WATCH_ACT && events_i.activity &&
                (mode == ITM_LOOPED || status_read_i)) begin
               nxt_phase = ITM_WATCH_INACT;
            end else if (phase_ff == ITM_WATCH_INACT && events_i.inactivity &&
                         (mode == ITM_LOOPED || status_read_i)) begin
               nxt_phase = ITM_WATCH_ACT;
            end
            // Autosleep honoured only here
            wake_req = meas_ff.autosleep && phase_ff == ITM_WATCH_INACT &&
                       events_i.inactivity;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         phase_ff <= ITM_WATCH_ACT;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // ==============================================================
   // Interrupt pins
   logic act_ev, inact_ev;
   logic pin_a, pin_a_oe_n, pin_b, pin_b_oe_n;

   always_comb begin
      // Detectors not being watched raise nothing
      act_ev   = events_i.activity & act_watch;
      inact_ev = events_i.inactivity & inact_watch;
   end

   itm_pin_drv u_itm_pin_drv_a (
      .clk_i      (clk_i),
      .reset_n_i  (reset_n_i),
      .map_i      (map_a_ff),
      .events_i   (events_i),
      .act_ev_i   (act_ev),
      .inact_ev_i (inact_ev),
      .pin_o      (pin_a),
      .pin_oe_n_o (pin_a_oe_n)
   );

   itm_pin_drv u_itm_pin_drv_b (
      .clk_i      (clk_i),
      .reset_n_i  (reset_n_i),
      .map_i      (map_b_ff),
      .events_i   (events_i),
      .act_ev_i   (act_ev),
      .inact_ev_i (inact_ev),
      .pin_o      (pin_b),
      .pin_oe_n_o (pin_b_oe_n)
   );

   // ==============================================================
   // Decoded timing and status outputs
   logic [15:0] odr_ff,  nxt_odr;
   logic [31:0] wake_ff, nxt_wake;
   logic        act_w_ff, inact_w_ff, wake_o_ff, ack_ff;
   logic        nxt_act_w, nxt_inact_w, nxt_wake_o, nxt_ack;
   logic [31:0] ms;

   always_comb begin
      case (rate_ff.output_rate_sel)
         3'h0:    nxt_odr = 16'(`ITM_ODR_HZ_0);
         3'h1:    nxt_odr = 16'(`ITM_ODR_HZ_1);
         3'h2:    nxt_odr = 16'(`ITM_ODR_HZ_2);
         3'h3:    nxt_odr = 16'(`ITM_ODR_HZ_3);
         3'h4:    nxt_odr = 16'(`ITM_ODR_HZ_4);
         default: nxt_odr = 16'h0000; // Undefined codes report zero
      endcase
      case (rate_ff.wake_timer_period)
         3'h0:    ms = 32'(`ITM_WAKE_MS_0);
         3'h1:    ms = 32'(`ITM_WAKE_MS_1);
         3'h2:    ms = 32'(`ITM_WAKE_MS_2);
         3'h3:    ms = 32'(`ITM_WAKE_MS_3);
         3'h4:    ms = 32'(`ITM_WAKE_MS_4);
         3'h5:    ms = 32'(`ITM_WAKE_MS_5);
         3'h6:    ms = 32'(`ITM_WAKE_MS_6);
         default: ms = 32'(`ITM_WAKE_MS_7);
      endcase
      // Longest period fits: 30720 ms * 10000 below 2^32
      nxt_wake = 32'(ms * CYC_PER_MS);
      // Watch, sleep and ack flags lag the chaining logic by one edge
      nxt_act_w   = act_watch;
      nxt_inact_w = inact_watch;
      nxt_wake_o  = wake_req;
      nxt_ack     = (mode != ITM_LOOPED);
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         odr_ff     <= 16'h0000;
         wake_ff    <= 32'h0000_0000;
         act_w_ff   <= 1'b0;
         inact_w_ff <= 1'b0;
         wake_o_ff  <= 1'b0;
         ack_ff     <= 1'b0;
      end else begin
         odr_ff     <= nxt_odr;
         wake_ff    <= nxt_wake;
         act_w_ff   <= nxt_act_w;
         inact_w_ff <= nxt_inact_w;
         wake_o_ff  <= nxt_wake_o;
         ack_ff     <= nxt_ack;
      end
   end

   assign rdata_o            = rdata_ff;
   assign irq_pin_a_o        = pin_a;
   assign irq_pin_a_oe_n_o   = pin_a_oe_n;
   assign irq_pin_b_o        = pin_b;
   assign irq_pin_b_oe_n_o   = pin_b_oe_n;
   assign rate_o             = rate_ff;
   assign meas_o             = meas_ff;
   assign odr_hz_o           = odr_ff;
   assign wake_cycles_o      = wake_ff;
   assign activity_watch_o   = act_w_ff;
   assign inactivity_watch_o = inact_w_ff;
   assign enter_wake_o       = wake_o_ff;
   assign host_ack_needed_o  = ack_ff;
endmodule

// ==============================================================
// One interrupt pin: mapped OR, polarity and float
module itm_pin_drv (
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   input  wire itm_pkg::itm_map_t    map_i,
   input  wire itm_pkg::itm_events_t events_i,
   input  wire logic                 act_ev_i,
   input  wire logic                 inact_ev_i,
   output logic                      pin_o,
   output logic                      pin_oe_n_o
);
   import itm_pkg::*;

   logic pin_ff,      nxt_pin;
   logic pin_oe_n_ff, nxt_pin_oe_n;
   logic cond;
   logic mapped;

   always_comb begin
      // Level tracks polarity while floating, so a new map drives cleanly
      mapped       = map_i.awake | map_i.activity | map_i.inactivity | map_i.sample_ready;
      // OR of every mapped condition
      cond         = (map_i.awake & events_i.awake) | (map_i.activity & act_ev_i) |
                     (map_i.inactivity & inact_ev_i) |
                     (map_i.sample_ready & events_i.sample_ready);
      nxt_pin      = cond ^ map_i.active_low;
      // Float pin with nothing mapped
      nxt_pin_oe_n = ~mapped;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_ff      <= 1'b0;
         pin_oe_n_ff <= 1'b1;
      end else begin
         pin_ff      <= nxt_pin;
         pin_oe_n_ff <= nxt_pin_oe_n;
      end
   end

   assign pin_o      = pin_ff;
   assign pin_oe_n_o = pin_oe_n_ff;
endmodule

// ===== hdl/itm_consts.svh
// Purpose: Constants for the interrupt routing and timing control bank
// Assumes: Byte-wide registers at printed offsets
// Notes:   Included by the design only
`ifndef ITM_CONSTS_SVH
`define ITM_CONSTS_SVH
// ==============================================================
// Register offsets
`define ITM_OFS_PIN_A_MAP    8'h3b
`define ITM_OFS_PIN_B_MAP    8'h3c
`define ITM_OFS_RATE_SYNC    8'h3d
`define ITM_OFS_MEASUREMENT_CONTROL      8'h3e
// ==============================================================
// Reset values and writable masks
`define ITM_RST_VAL          8'h00
`define ITM_MAP_WMASK        8'hf1
`define ITM_RATE_WMASK       8'hff
`define ITM_MEAS_WMASK       8'hff
// ==============================================================
// Map field positions
`define ITM_MAP_LOW_BIT      7
`define ITM_MAP_AWAKE_BIT    6
`define ITM_MAP_ACT_BIT      5
`define ITM_MAP_INACT_BIT    4
`define ITM_MAP_RDY_BIT      0
// ==============================================================
// Chaining codes
`define ITM_CHAIN_DEFAULT    2'h0
`define ITM_CHAIN_LINKED     2'h1
`define ITM_CHAIN_LOOPED     2'h2
// ==============================================================
// Wake timer periods in ms, and cycles per ms at 10 MHz
`define ITM_CLK_HZ           10000000
`define ITM_CYC_PER_MS       (`ITM_CLK_HZ / 1000)
`define ITM_WAKE_MS_0        65
`define ITM_WAKE_MS_1        130
`define ITM_WAKE_MS_2        260
`define ITM_WAKE_MS_3        640
`define ITM_WAKE_MS_4        2560
`define ITM_WAKE_MS_5        5120
`define ITM_WAKE_MS_6        10240
`define ITM_WAKE_MS_7        30720
// ==============================================================
// Data rates in Hz
`define ITM_ODR_HZ_0         320
`define ITM_ODR_HZ_1         640
`define ITM_ODR_HZ_2         1280
`define ITM_ODR_HZ_3         2560
`define ITM_ODR_HZ_4         5120
`endif

// ===== hdl/itm_pkg.sv
// Purpose: Types for the interrupt routing and timing control bank
// Assumes: Constants come from itm_consts.svh
// Notes:   Field layouts as packed structs
package itm_pkg;
   // ==============================================================
   // Register layouts
   typedef struct packed {
      logic       active_low;
      logic       awake;
      logic       activity;
      logic       inactivity;
      logic [2:0] rsvd;
      logic       sample_ready;
   } itm_map_t;

   typedef struct packed {
      logic [2:0] output_rate_sel;
      logic [2:0] wake_timer_period;
      logic       external_clock_enable;
      logic       external_trigger_enable;
   } itm_rate_t;

   typedef struct packed {
      logic       overrange_disable;
      logic       autosleep;
      logic [1:0] act_inact_chaining;
      logic       low_noise;
      logic [2:0] bandwidth;
   } itm_meas_t;

   // Event conditions from detection logic
   typedef struct packed {
      logic awake;
      logic activity;
      logic inactivity;
      logic sample_ready;
   } itm_events_t;

   // Register access strobe
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } itm_req_t;

   // Effective processing mode
   typedef enum logic [1:0] {
      ITM_SIMULTANEOUS,
      ITM_LINKED,
      ITM_LOOPED
   } itm_mode_t;

   // Linked and looped detection phase
   typedef enum logic {
      ITM_WATCH_ACT,
      ITM_WATCH_INACT
   } itm_phase_t;
endpackage

// ===== verif/itm_ctl_checker.sv
// Purpose: Port-level assertions for the control bank
// Assumes: One clock, async active-low reset
// Notes:   Bound into every itm_ctl instance
`timescale 1ns/10ps
module itm_ctl_checker #(
   parameter int unsigned CYC_PER_MS = 10000
) (
   input wire logic               clk_i,
   input wire logic               reset_n_i,
   input wire itm_pkg::itm_req_t  req_i,
   input wire logic               activity_detect_enable_i,
   input wire logic               inactivity_detect_enable_i,
   input wire logic [7:0]         rdata_o,
   input wire logic               irq_pin_a_oe_n_o,
   input wire itm_pkg::itm_rate_t rate_o,
   input wire itm_pkg::itm_meas_t meas_o,
   input wire logic [15:0]        odr_hz_o,
   input wire logic [31:0]        wake_cycles_o,
   input wire logic               activity_watch_o,
   input wire logic               inactivity_watch_o,
   input wire logic               enter_wake_o,
   input wire logic               host_ack_needed_o
);
   import itm_pkg::*;
   // ==============================================================
   // Helpers
   localparam int WAKE_MS [8] = '{65, 130, 260, 640, 2560, 5120, 10240, 30720};
   logic both_en;
   logic chained;
   logic looped;
   assign both_en = activity_detect_enable_i && inactivity_detect_enable_i;
   assign chained = both_en && (meas_o.act_inact_chaining inside {2'h1, 2'h2});
   assign looped  = both_en && (meas_o.act_inact_chaining == 2'h2);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // ==============================================================
   // Sequences
   sequence map_a_emptied;
      req_i.wr && req_i.addr == 8'h3b && (req_i.wdata & 8'h71) == 8'h00;
   endsequence
   sequence map_a_untouched;
      !(req_i.wr && req_i.addr == 8'h3b);
   endsequence
   sequence chain_settled;
      chained [*3];
   endsequence
   // ==============================================================
   // Assertions
   chk_pin_a_hiz: assert property (map_a_emptied ##1 map_a_untouched |=> irq_pin_a_oe_n_o)
      else $error("pin a driven with empty map");
   chk_unmapped_read: assert property (req_i.rd && !(req_i.addr inside {[8'h3b:8'h3e]})
      |=> rdata_o == 8'h00) else $error("unmapped read not zero");
   chk_rate_write: assert property (req_i.wr && req_i.addr == 8'h3d
      |=> rate_o == itm_rate_t'($past(req_i.wdata))) else $error("rate write lost");
   chk_meas_write: assert property (req_i.wr && req_i.addr == 8'h3e
      |=> meas_o == itm_meas_t'($past(req_i.wdata))) else $error("meas write lost");
   chk_odr_decode: assert property (rate_o.output_rate_sel <= 3'h4
      |=> odr_hz_o == (16'd320 << $past(rate_o.output_rate_sel))) else $error("bad rate");
   chk_wake_decode: assert property (1'b1
      |=> wake_cycles_o == WAKE_MS[$past(rate_o.wake_timer_period)] * CYC_PER_MS)
      else $error("bad wake period");
   chk_ack_mode: assert property (1'b1 |=> host_ack_needed_o == !$past(looped))
      else $error("ack need wrong");
   chk_chain_single: assert property (chain_settled
      |-> $onehot({activity_watch_o, inactivity_watch_o})) else $error("two detectors live");
   chk_simul_watch: assert property (!chained |=> {activity_watch_o, inactivity_watch_o}
      == $past({activity_detect_enable_i, inactivity_detect_enable_i}))
      else $error("watch not enables");
   chk_sleep_gate: assert property (!(meas_o.autosleep && chained) |=> !enter_wake_o)
      else $error("sleep request while gated");
endmodule
bind itm_ctl itm_ctl_checker #(.CYC_PER_MS(CYC_PER_MS)) u_itm_ctl_checker (
   .clk_i, .reset_n_i, .req_i, .activity_detect_enable_i, .inactivity_detect_enable_i,
   .rdata_o, .irq_pin_a_oe_n_o, .rate_o, .meas_o, .odr_hz_o, .wake_cycles_o,
   .activity_watch_o, .inactivity_watch_o, .enter_wake_o, .host_ack_needed_o
);

// ===== verif/itm_host.sv
// Purpose: Host model issuing register strobes and status reads
// Assumes: Strobes change 1 ns after the rising edge
// Notes:   Idle lines show inverted data so stale values never match
`timescale 1ns/10ps
module itm_host (
   input  wire logic         clk_i,
   input  wire logic [7:0]   rdata_i,
   output itm_pkg::itm_req_t req_o,
   output logic              status_read_o
);
   import itm_pkg::*;
   initial begin
      req_o         = '0;
      status_read_o = 1'b0;
   end
   // ==============================================================
   // Bus cycles
   task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      req_o = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i);
      #1;
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cyc(1'b0, a, 8'h00);
      d = rdata_i;
   endtask
   // Status read acknowledges detector interrupts
   task automatic ack();
      @(posedge clk_i);
      #1;
      status_read_o = 1'b1;
      @(posedge clk_i);
      #1;
      status_read_o = 1'b0;
   endtask
endmodule

// ===== verif/interrupt_timing_measurement_control_ctl_tb_top.sv
// Purpose: Self-checking bench for the control bank
// Assumes: 10 MHz clock, wake count scaled to 10 cycles per ms
// Notes:   Events and enables driven 1 ns after the edge
`timescale 1ns/10ps
module interrupt_timing_measurement_control_ctl_tb_top;
   import itm_pkg::*;
   localparam int unsigned CPM = 10;
   logic        clk_i;
   logic        reset_n_i;
   itm_req_t    req_i;
   itm_events_t events_i;
   logic        activity_detect_enable_i;
   logic        inactivity_detect_enable_i;
   logic        status_read_i;
   logic [7:0]  rdata_o;
   logic        irq_pin_a_o, irq_pin_a_oe_n_o, irq_pin_b_o, irq_pin_b_oe_n_o;
   itm_rate_t   rate_o;
   itm_meas_t   meas_o;
   logic [15:0] odr_hz_o;
   logic [31:0] wake_cycles_o;
   logic        activity_watch_o, inactivity_watch_o, enter_wake_o, host_ack_needed_o;
   int          n_mismatch = 0;
   int          compares   = 0;
   itm_ctl #(.CYC_PER_MS(CPM)) u_itm_ctl (
      .clk_i, .reset_n_i, .req_i, .events_i, .activity_detect_enable_i,
      .inactivity_detect_enable_i, .status_read_i, .rdata_o, .irq_pin_a_o,
      .irq_pin_a_oe_n_o, .irq_pin_b_o, .irq_pin_b_oe_n_o, .rate_o, .meas_o, .odr_hz_o,
      .wake_cycles_o, .activity_watch_o, .inactivity_watch_o, .enter_wake_o,
      .host_ack_needed_o
   );
   itm_host u_itm_host (.clk_i, .rdata_i(rdata_o), .req_o(req_i), .status_read_o(status_read_i));
   // ==============================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // ==============================================================
   // Scenarios
   task automatic t_reset();
      logic [7:0] d;
      for (int a = 8'h3a; a <= 8'h3f; a++) begin
         u_itm_host.rd(8'(a), d);
         chk(d, 8'h00);
      end
      chk({irq_pin_a_oe_n_o, irq_pin_b_oe_n_o}, 2'b11);
      $display("test reset done");
   endtask
   task automatic t_pins();
      logic [6:0] fmap [4] = '{7'h40, 7'h20, 7'h10, 7'h01};
      logic [7:0] m, d;
      activity_detect_enable_i   = 1'b1;
      inactivity_detect_enable_i = 1'b1;
      for (int p = 0; p < 2; p++) begin
         for (int pol = 0; pol < 4; pol += 2) begin
            for (int f = 0; f < 4; f++) begin
               m = {pol[1], fmap[f]};
               u_itm_host.wr(8'(8'h3b + p), m | 8'h0e);
               u_itm_host.rd(8'(8'h3b + p), d);
               chk(d, m);
               events_i = itm_events_t'(4'b1000 >> f);
               wt(1);
               chk(p ? {irq_pin_b_o, irq_pin_b_oe_n_o} : {irq_pin_a_o, irq_pin_a_oe_n_o},
                   {~pol[1], 1'b0});
               events_i = itm_events_t'(~(4'b1000 >> f));
               wt(1);
               chk(p ? irq_pin_b_o : irq_pin_a_o, pol[1]);
               events_i = '0;
            end
         end
      end
      u_itm_host.wr(8'h3b, 8'h71);
      events_i = itm_events_t'(4'b0010);
      wt(2);
      chk(irq_pin_a_o, 1'b1);
      u_itm_host.wr(8'h3b, 8'h80);
      wt(2);
      chk(irq_pin_a_oe_n_o, 1'b1);
      events_i = '0;
      $display("test pins done");
   endtask
   task automatic t_rate();
      int         wms [8] = '{65, 130, 260, 640, 2560, 5120, 10240, 30720};
      logic [7:0] v, d;
      for (int k = 0; k < 8; k++) begin
         v = {3'(k % 5), 3'(k), 2'(k)};
         u_itm_host.wr(8'h3d, v);
         u_itm_host.rd(8'h3d, d);
         chk(d, v);
         chk(rate_o, v);
         chk(odr_hz_o, 16'd320 << (k % 5));
         chk(wake_cycles_o, wms[k] * CPM);
      end
      u_itm_host.wr(8'h3d, 8'ha0);
      wt(2);
      chk(odr_hz_o, 16'h0000);
      $display("test rate done");
   endtask
   task automatic t_chain();
      u_itm_host.wr(8'h3e, 8'h49);
      events_i = itm_events_t'(4'b0010);
      wt(3);
      chk(meas_o, 8'h49);
      chk({enter_wake_o, host_ack_needed_o, activity_watch_o, inactivity_watch_o}, 4'h7);
      events_i = '0;
      u_itm_host.wr(8'h3e, 8'h60);
      wt(3);
      chk({host_ack_needed_o, activity_watch_o, inactivity_watch_o}, 3'b010);
      events_i = itm_events_t'(4'b0100);
      wt(1);
      events_i = '0;
      wt(3);
      chk({activity_watch_o, inactivity_watch_o}, 2'b01);
      events_i = itm_events_t'(4'b0010);
      wt(1);
      chk(enter_wake_o, 1'b1);
      events_i = '0;
      inactivity_detect_enable_i = 1'b0;
      wt(3);
      chk({host_ack_needed_o, activity_watch_o, inactivity_watch_o}, 3'b110);
      inactivity_detect_enable_i = 1'b1;
      u_itm_host.wr(8'h3e, 8'h50);
      events_i = itm_events_t'(4'b0100);
      wt(3);
      chk({host_ack_needed_o, activity_watch_o, inactivity_watch_o}, 3'b110);
      u_itm_host.ack();
      events_i = '0;
      wt(3);
      chk({activity_watch_o, inactivity_watch_o}, 2'b01);
      $display("test chain done");
   endtask
   // ==============================================================
   // Run control
   task automatic end_sim();
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Run needs under 2000 cycles; generous margin
   initial begin
      #3000000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      reset_n_i                  = 1'b0;
      events_i                   = '0;
      activity_detect_enable_i   = 1'b0;
      inactivity_detect_enable_i = 1'b0;
      repeat (16) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      t_reset();
      t_pins();
      t_rate();
      t_chain();
      end_sim();
   end
endmodule
